// [rtl/light_wake_pkg.sv]
package light_wake_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_BUTTONS = 12;
	localparam int NUM_PINS    = 8;
	localparam int NUM_KEYS    = 6;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_WAKE_LEN   = 8'h33;
	localparam logic [7:0] OFS_WAKE_KEYS0 = 8'h34;
	localparam logic [7:0] OFS_WAKE_KEYS1 = 8'h35;
	localparam logic [7:0] OFS_WAKE_KEYS2 = 8'h36;
	localparam logic [7:0] OFS_LIGHT_MAP0 = 8'h37;
	localparam logic [7:0] OFS_LIGHT_MAP1 = 8'h38;
	localparam logic [7:0] OFS_LIGHT_MAP2 = 8'h39;
	localparam logic [7:0] OFS_LIGHT_MAP3 = 8'h3A;
	localparam logic [7:0] OFS_GRP0_HIGH  = 8'h3B;
	localparam logic [7:0] OFS_GRP0_LOW   = 8'h3C;
	localparam logic [7:0] OFS_GRP1_HIGH  = 8'h3D;
	localparam logic [7:0] OFS_GRP1_LOW   = 8'h3E;
	localparam logic [7:0] OFS_HYST       = 8'h3F;
	localparam logic [7:0] OFS_AUTOLIGHT  = 8'h43;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_WAKE_LEN  = 8'h00;
	localparam logic [7:0] RST_WAKE_KEYS = 8'h00;
	localparam logic [7:0] RST_LIGHT_MAP = 8'h00;
	localparam logic [7:0] RST_MASK      = 8'h00;
	localparam logic [7:0] RST_HYST      = 8'h02;
	localparam logic [7:0] RST_AUTOLIGHT = 8'hFF;

	// ==========================================================
	// Fields and codes
	localparam logic [7:0]  MASK_HIGH_USED = 8'h7F;
	localparam logic [7:0]  HYST_MAX       = 8'h64;
	localparam logic [15:0] SEGMENT_ONLY   = 16'h4000;
	localparam int          EVB_CCW        = 12;
	localparam int          EVB_CW         = 13;
	localparam int          EVB_WHEEL      = 14;
	localparam logic [3:0]  MAP_GROUP0     = 4'hC;
	localparam logic [3:0]  MAP_GROUP1     = 4'hD;
	localparam logic [3:0]  MAP_CCW        = 4'hE;
	localparam logic [3:0]  MAP_CW         = 4'hF;
	localparam logic [3:0]  KEY_WHEEL      = 4'hC;
	localparam logic [3:0]  KEY_CCW        = 4'hD;
	localparam logic [3:0]  KEY_CW         = 4'hE;
	localparam logic [7:0]  WAKE_ANY       = 8'h00;
	localparam logic [7:0]  WAKE_SENSOR_OFF = 8'h06;
	localparam logic [31:0] PERCENT_FULL   = 32'h0000_0064;
endpackage : light_wake_pkg

// [rtl/wheel_segment_tracker.sv]
`timescale 1ns/1ps
module wheel_segment_tracker
	import light_wake_pkg::*;
#(
	parameter int POS_W = 10
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// Wheel state
	input  wire logic             touch,
	input  wire logic [POS_W-1:0] pos,
	input  wire logic [POS_W-1:0] pos_max,
	// Settings
	input  wire logic [3:0]       seg_count,
	input  wire logic [7:0]       hyst,
	// Current segment
	output logic      [2:0]       seg_idx
);

	// ==========================================================
	// Segment tracking
	logic [2:0]  cur_r;
	logic [2:0]  cur_nxt;
	logic        touch_r;
	logic [2:0]  raw;
	logic [31:0] pos_n;
	logic [31:0] hys_t;
	logic [31:0] up_b;
	logic [31:0] dn_b;

	// Raw segment: s is reached once pos*N >= s*max, so no divider is needed.
	always_comb begin
		raw = 3'h0;
		for (int s = 1; s < 8; s++) begin
			if (32'(s) < 32'(seg_count) &&
			    32'(pos) * 32'(seg_count) >= 32'(s) * 32'(pos_max)) begin
				raw = 3'(s);
			end
		end
	end

	// Scaled by 100*N so that the percentage never needs a division.
	assign pos_n = 32'(pos) * 32'(seg_count) * PERCENT_FULL;
	assign hys_t = 32'(hyst) * 32'(pos_max) * 32'(seg_count);
	assign up_b  = (32'(cur_r) + 32'h1) * 32'(pos_max) * PERCENT_FULL;
	assign dn_b  = 32'(cur_r) * 32'(pos_max) * PERCENT_FULL;

	// A new touch lands on the raw segment of its own position; while held it
	// steps one segment at a time, and only after crossing a border by the
	// hysteresis margin. Landing waits for the first touched cycle because
	// the position shown before touch-down is stale and would trap the
	// index in a wrong segment behind the hysteresis.
	always_comb begin
		cur_nxt = cur_r;
		if (!touch || !touch_r || 32'(cur_r) >= 32'(seg_count)) begin
			cur_nxt = raw;
		end else if (32'(cur_r) + 32'h1 < 32'(seg_count) && pos_n >= up_b + hys_t) begin
			cur_nxt = cur_r + 3'h1;
		end else if (cur_r != 3'h0 && pos_n + hys_t <= dn_b) begin
			cur_nxt = cur_r - 3'h1;
		end
	end

	// Register stage.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cur_r   <= 3'h0;
			touch_r <= 1'b0;
		end else begin
			cur_r   <= cur_nxt;
			touch_r <= touch;
		end
	end

	assign seg_idx = cur_r;

	// ==========================================================
	// Checks
	property p_seg_range;
		@(posedge clk_sys) disable iff (srst)
		(seg_count != 4'h0 && $stable(seg_count)) |-> (4'(cur_r) < seg_count);
	endproperty
	a_seg_range: assert property (p_seg_range) else $error("segment out of range");

	property p_seg_step;
		@(posedge clk_sys) disable iff (srst)
		(touch && $past(touch) && $past(touch, 2) && $stable(seg_count) &&
		 cur_r != $past(cur_r))
		|-> (cur_r == $past(cur_r) + 3'h1 || cur_r == $past(cur_r) - 3'h1);
	endproperty
	a_seg_step: assert property (p_seg_step) else $error("segment jumped while held");

endmodule : wheel_segment_tracker

// [rtl/touch_event_light_wake_mapper.sv]
`timescale 1ns/1ps
module touch_event_light_wake_mapper
	import light_wake_pkg::*;
#(
	parameter int POS_W = 10
) (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// Register port from the serial host engine
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_we,
	input  wire logic                   reg_re,
	output logic      [7:0]             reg_rdata,
	// Sensing engine
	input  wire logic [NUM_BUTTONS-1:0] btn_touch,
	input  wire logic                   wheel_touch,
	input  wire logic                   rot_cw,
	input  wire logic                   rot_ccw,
	input  wire logic [POS_W-1:0]       wheel_pos,
	input  wire logic [POS_W-1:0]       wheel_position_max,
	// Wake control
	input  wire logic                   doze_active,
	input  wire logic                   input_pin_wake,
	input  wire logic                   host_wake_cmd,
	output logic                        wake_pulse,
	// Output pins
	input  wire logic [NUM_PINS-1:0]    host_pin_value,
	output logic      [NUM_PINS-1:0]    output_pin
);

	// ==========================================================
	// Register file
	logic [7:0]  wake_len_r, wake_len_nxt;
	logic [23:0] wake_keys_r, wake_keys_nxt;
	logic [31:0] map_r, map_nxt;
	logic [15:0] grp0_r, grp0_nxt;
	logic [15:0] grp1_r, grp1_nxt;
	logic [7:0]  hyst_r, hyst_nxt;
	logic [7:0]  auto_r, auto_nxt;
	logic [7:0]  rdata_r, rdata_nxt;

	// Writes land byte by byte; every mask bit is its own flip-flop.
	always_comb begin
		wake_len_nxt  = wake_len_r;
		wake_keys_nxt = wake_keys_r;
		map_nxt       = map_r;
		grp0_nxt      = grp0_r;
		grp1_nxt      = grp1_r;
		hyst_nxt      = hyst_r;
		auto_nxt      = auto_r;
		if (reg_we) begin
			case (reg_addr)
				OFS_WAKE_LEN:   wake_len_nxt = reg_wdata;
				OFS_WAKE_KEYS0: wake_keys_nxt[23:16] = reg_wdata;
				OFS_WAKE_KEYS1: wake_keys_nxt[15:8] = reg_wdata;
				OFS_WAKE_KEYS2: wake_keys_nxt[7:0] = reg_wdata;
				OFS_LIGHT_MAP0: map_nxt[31:24] = reg_wdata;
				OFS_LIGHT_MAP1: map_nxt[23:16] = reg_wdata;
				OFS_LIGHT_MAP2: map_nxt[15:8] = reg_wdata;
				OFS_LIGHT_MAP3: map_nxt[7:0] = reg_wdata;
				OFS_GRP0_HIGH:  grp0_nxt[15:8] = reg_wdata & MASK_HIGH_USED;
				OFS_GRP0_LOW:   grp0_nxt[7:0] = reg_wdata;
				OFS_GRP1_HIGH:  grp1_nxt[15:8] = reg_wdata & MASK_HIGH_USED;
				OFS_GRP1_LOW:   grp1_nxt[7:0] = reg_wdata;
				// Out-of-range percentages are held at full scale.
				OFS_HYST:       hyst_nxt = (reg_wdata > HYST_MAX) ? HYST_MAX : reg_wdata;
				OFS_AUTOLIGHT:  auto_nxt = reg_wdata;
				default:        ;
			endcase
		end
	end

	// Read mux; unmapped offsets and the reserved mask bit read as zero.
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_re) begin
			case (reg_addr)
				OFS_WAKE_LEN:   rdata_nxt = wake_len_r;
				OFS_WAKE_KEYS0: rdata_nxt = wake_keys_r[23:16];
				OFS_WAKE_KEYS1: rdata_nxt = wake_keys_r[15:8];
				OFS_WAKE_KEYS2: rdata_nxt = wake_keys_r[7:0];
				OFS_LIGHT_MAP0: rdata_nxt = map_r[31:24];
				OFS_LIGHT_MAP1: rdata_nxt = map_r[23:16];
				OFS_LIGHT_MAP2: rdata_nxt = map_r[15:8];
				OFS_LIGHT_MAP3: rdata_nxt = map_r[7:0];
				OFS_GRP0_HIGH:  rdata_nxt = grp0_r[15:8];
				OFS_GRP0_LOW:   rdata_nxt = grp0_r[7:0];
				OFS_GRP1_HIGH:  rdata_nxt = grp1_r[15:8];
				OFS_GRP1_LOW:   rdata_nxt = grp1_r[7:0];
				OFS_HYST:       rdata_nxt = hyst_r;
				OFS_AUTOLIGHT:  rdata_nxt = auto_r;
				default:        rdata_nxt = 8'h00;
			endcase
		end
	end

	// Register stage for the register file.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wake_len_r  <= RST_WAKE_LEN;
			wake_keys_r <= {3{RST_WAKE_KEYS}};
			map_r       <= {4{RST_LIGHT_MAP}};
			grp0_r      <= {RST_MASK, RST_MASK};
			grp1_r      <= {RST_MASK, RST_MASK};
			hyst_r      <= RST_HYST;
			auto_r      <= RST_AUTOLIGHT;
			rdata_r     <= 8'h00;
		end else begin
			wake_len_r  <= wake_len_nxt;
			wake_keys_r <= wake_keys_nxt;
			map_r       <= map_nxt;
			grp0_r      <= grp0_nxt;
			grp1_r      <= grp1_nxt;
			hyst_r      <= hyst_nxt;
			auto_r      <= auto_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ==========================================================
	// Rotation state and edge history
	logic                   cw_r, cw_nxt;
	logic                   ccw_r, ccw_nxt;
	logic [NUM_BUTTONS-1:0] btn_prev_r;
	logic                   wheel_prev_r;

	// Direction holds until the other direction or a release.
	always_comb begin
		cw_nxt  = cw_r;
		ccw_nxt = ccw_r;
		if (rot_cw) begin
			cw_nxt  = 1'b1;
			ccw_nxt = 1'b0;
		end else if (rot_ccw) begin
			cw_nxt  = 1'b0;
			ccw_nxt = 1'b1;
		end else if (!wheel_touch) begin
			cw_nxt  = 1'b0;
			ccw_nxt = 1'b0;
		end
	end

	// Register stage for rotation and history.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cw_r         <= 1'b0;
			ccw_r        <= 1'b0;
			btn_prev_r   <= '0;
			wheel_prev_r <= 1'b0;
		end else begin
			cw_r         <= cw_nxt;
			ccw_r        <= ccw_nxt;
			btn_prev_r   <= btn_touch;
			wheel_prev_r <= wheel_touch;
		end
	end

	// ==========================================================
	// Groups and wheel segments
	logic [15:0] ev_vec;
	logic [15:0] grp0_eff;
	logic        seg_mode;
	logic        grp0_ev;
	logic        grp1_ev;
	logic [7:0]  seg_pin;
	logic [3:0]  seg_count;
	logic [2:0]  seg_rank [NUM_PINS];
	logic [2:0]  seg_idx;

	// Bit positions of the event vector match the mask layout directly.
	assign ev_vec   = {1'b0, wheel_touch, cw_r, ccw_r, btn_touch};
	// The segment bit counts only as the sole group0 member.
	assign seg_mode = (grp0_r == SEGMENT_ONLY);
	assign grp0_eff = grp0_r & ~SEGMENT_ONLY;
	assign grp0_ev  = |(grp0_eff & ev_vec);
	assign grp1_ev  = |(grp1_r & ev_vec);

	// Rank each segment pin by how many segment pins sit below it.
	always_comb begin
		seg_count = 4'h0;
		for (int i = 0; i < NUM_PINS; i++) begin
			seg_pin[i]  = seg_mode && auto_r[i] && map_r[4*i +: 4] == MAP_GROUP0;
			seg_rank[i] = seg_count[2:0];
			seg_count   = seg_count + {3'h0, seg_pin[i]};
		end
	end

	wheel_segment_tracker #(
		.POS_W (POS_W)
	) u_seg (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.touch     (wheel_touch),
		.pos       (wheel_pos),
		.pos_max   (wheel_position_max),
		.seg_count (seg_count),
		.hyst      (hyst_r),
		.seg_idx   (seg_idx)
	);

	// ==========================================================
	// Output pins
	logic [NUM_PINS-1:0] out_r, out_nxt;
	logic [NUM_PINS-1:0] sel;

	// Decode each pin's field; pins sharing a code switch together, except group0 pins in segment mode, which light one per segment.
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			case (map_r[4*i +: 4])
				MAP_GROUP0: sel[i] = seg_mode ? (wheel_touch && wheel_prev_r &&
				                                 seg_idx == seg_rank[i])
				                              : grp0_ev;
				MAP_GROUP1: sel[i] = grp1_ev;
				MAP_CCW:    sel[i] = ccw_r;
				MAP_CW:     sel[i] = cw_r;
				default:    sel[i] = btn_touch[map_r[4*i +: 4]];
			endcase
			out_nxt[i] = auto_r[i] ? sel[i] : host_pin_value[i];
		end
	end

	// Register stage for the pins.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_r <= '0;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign output_pin = out_r;

	// ==========================================================
	// Wake-up sequence
	logic       key_hit;
	logic [3:0] key_code;
	logic [3:0] key_want;
	logic [2:0] idx_r, idx_nxt;
	logic       wake_r, wake_nxt;

	// New presses become key codes; the lowest code wins a tie, so two
	// simultaneous presses count as one key rather than a false mismatch.
	always_comb begin
		key_hit  = 1'b1;
		key_code = KEY_CW;
		if (!rot_cw) begin
			key_code = KEY_CCW;
			key_hit  = rot_ccw;
		end
		if (rot_ccw) begin
			key_code = KEY_CCW;
		end
		if (wheel_touch && !wheel_prev_r) begin
			key_code = KEY_WHEEL;
			key_hit  = 1'b1;
		end
		for (int b = NUM_BUTTONS - 1; b >= 0; b--) begin
			if (btn_touch[b] && !btn_prev_r[b]) begin
				key_code = 4'(b);
				key_hit  = 1'b1;
			end
		end
	end

	assign key_want = wake_keys_r[4*idx_r +: 4];

	// Match keys in order; lengths of six or more disable sensor wake.
	always_comb begin
		idx_nxt  = idx_r;
		wake_nxt = 1'b0;
		if (!doze_active) begin
			idx_nxt = 3'h0;
		end else if (input_pin_wake || host_wake_cmd) begin
			wake_nxt = 1'b1;
			idx_nxt  = 3'h0;
		end else if (wake_len_r >= WAKE_SENSOR_OFF) begin
			idx_nxt = 3'h0;
		end else if (key_hit) begin
			if (wake_len_r == WAKE_ANY) begin
				wake_nxt = 1'b1;
			end else if (key_code == key_want) begin
				if (8'(idx_r) + 8'h1 == wake_len_r) begin
					wake_nxt = 1'b1;
					idx_nxt  = 3'h0;
				end else begin
					idx_nxt = idx_r + 3'h1;
				end
			end else begin
				idx_nxt = (key_code == wake_keys_r[3:0]) ? 3'h1 : 3'h0;
			end
		end
	end

	// Register stage for the matcher.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			idx_r  <= 3'h0;
			wake_r <= 1'b0;
		end else begin
			idx_r  <= idx_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign wake_pulse = wake_r;

	// ==========================================================
	// Checks
	property p_grp0_pair;
		@(posedge clk_sys) disable iff (srst)
		(auto_r[0] && map_r[3:0] == MAP_GROUP0 && grp0_r == 16'h0003 && |btn_touch[1:0])
		|=> output_pin[0];
	endproperty
	a_grp0_pair: assert property (p_grp0_pair) else $error("group0 pair did not light");

	property p_pin0_btn4;
		@(posedge clk_sys) disable iff (srst)
		(auto_r[0] && map_r[3:0] == 4'h4) |=> (output_pin[0] == $past(btn_touch[4]));
	endproperty
	a_pin0_btn4: assert property (p_pin0_btn4) else $error("pin0 not following button 4");

	property p_host_pin;
		@(posedge clk_sys) disable iff (srst)
		!auto_r[1] |=> (output_pin[1] == $past(host_pin_value[1]));
	endproperty
	a_host_pin: assert property (p_host_pin) else $error("manual pin not host driven");

	property p_cw_release;
		@(posedge clk_sys) disable iff (srst)
		(!wheel_touch && !rot_cw && !rot_ccw) |=> (!cw_r && !ccw_r);
	endproperty
	a_cw_release: assert property (p_cw_release) else $error("rotation not cleared");

	property p_wake_any;
		@(posedge clk_sys) disable iff (srst)
		(doze_active && wake_len_r == WAKE_ANY && key_hit) |=> wake_pulse;
	endproperty
	a_wake_any: assert property (p_wake_any) else $error("no wake on any event");

	property p_wake_off;
		@(posedge clk_sys) disable iff (srst)
		(doze_active && wake_len_r == WAKE_SENSOR_OFF && !input_pin_wake && !host_wake_cmd)
		|=> !wake_pulse;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("sensor woke disabled sequence");

	property p_restart;
		@(posedge clk_sys) disable iff (srst)
		(doze_active && !input_pin_wake && !host_wake_cmd && wake_len_r != WAKE_ANY &&
		 wake_len_r < WAKE_SENSOR_OFF && key_hit && key_code != key_want &&
		 key_code != wake_keys_r[3:0]) |=> (idx_r == 3'h0 && !wake_pulse);
	endproperty
	a_restart: assert property (p_restart) else $error("mismatch did not restart");

	property p_grp1_high;
		@(posedge clk_sys) disable iff (srst)
		(reg_we && reg_addr == OFS_GRP1_HIGH)
		|=> (grp1_r[15:8] == ($past(reg_wdata) & MASK_HIGH_USED));
	endproperty
	a_grp1_high: assert property (p_grp1_high) else $error("group1 high byte wrong");

	property p_hyst_range;
		@(posedge clk_sys) disable iff (srst)
		(reg_we && reg_addr == OFS_HYST) |=> (hyst_r <= HYST_MAX &&
		 (hyst_r == $past(reg_wdata) || $past(reg_wdata) > HYST_MAX));
	endproperty
	a_hyst_range: assert property (p_hyst_range) else $error("hysteresis above full scale");

endmodule : touch_event_light_wake_mapper

// [dv/sense_engine_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Sensing engine model
// Reports one scan per clock. Rotation steps are reported only while the
// wheel is touched, and a released wheel shows an inverted stale position
// so that nothing downstream can lean on it.
module sense_engine_model #(
	parameter int POS_W   = 10,
	parameter int POS_MAX = 1000
) (
	// Clock
	input  wire logic             clk_sys,
	// Requests from the bench
	input  wire logic [11:0]      btn_req,
	input  wire logic             whl_req,
	input  wire logic [POS_W-1:0] pos_req,
	input  wire logic             step_cw,
	input  wire logic             step_ccw,
	// Sensor reports
	output logic      [11:0]      btn_touch,
	output logic                  wheel_touch,
	output logic                  rot_cw,
	output logic                  rot_ccw,
	output logic      [POS_W-1:0] wheel_pos,
	output logic      [POS_W-1:0] wheel_position_max
);
	logic [POS_W-1:0] pos_r;

	// Quiet sensors until the first scan lands.
	initial begin
		btn_touch   = '0;
		wheel_touch = 1'b0;
		rot_cw      = 1'b0;
		rot_ccw     = 1'b0;
		pos_r       = '0;
	end

	// One scan per clock; steps need a finger on the wheel.
	always @(posedge clk_sys) begin
		btn_touch   <= btn_req;
		wheel_touch <= whl_req;
		rot_cw      <= step_cw & whl_req;
		rot_ccw     <= step_ccw & whl_req;
		pos_r       <= whl_req ? pos_req : pos_r;
	end

	// A released wheel carries no valid position.
	assign wheel_pos          = wheel_touch ? pos_r : ~pos_r;
	assign wheel_position_max = POS_W'(POS_MAX);
endmodule : sense_engine_model

// [dv/test_touch_event_light_wake_mapper.sv]
`timescale 1ns/1ps
module test_touch_event_light_wake_mapper;
	import light_wake_pkg::*;
	// ==========================================================
	// Signals
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_we = 1'b0;
	logic        reg_re = 1'b0;
	logic [7:0]  reg_rdata;
	logic [11:0] btn_touch, btn_req = 12'h000;
	logic        wheel_touch, rot_cw, rot_ccw;
	logic        whl_req = 1'b0;
	logic        step_cw = 1'b0;
	logic        step_ccw = 1'b0;
	logic [9:0]  wheel_pos, wheel_position_max;
	logic [9:0]  pos_req = 10'h000;
	logic        doze_active = 1'b0;
	logic        input_pin_wake = 1'b0;
	logic        host_wake_cmd = 1'b0;
	logic        wake_pulse;
	logic [7:0]  host_pin_value = 8'h00;
	logic [7:0]  output_pin;
	int          fail_count = 0;
	int          comparisons = 0;
	int          wakes = 0;
	int          base;

	// ==========================================================
	// Instances
	touch_event_light_wake_mapper #(.POS_W(10)) i_touch_event_light_wake_mapper (
		.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .btn_touch(btn_touch),
		.wheel_touch(wheel_touch), .rot_cw(rot_cw), .rot_ccw(rot_ccw),
		.wheel_pos(wheel_pos), .wheel_position_max(wheel_position_max),
		.doze_active(doze_active), .input_pin_wake(input_pin_wake),
		.host_wake_cmd(host_wake_cmd), .wake_pulse(wake_pulse),
		.host_pin_value(host_pin_value), .output_pin(output_pin));
	sense_engine_model #(.POS_W(10), .POS_MAX(1000)) i_sense_engine_model (
		.clk_sys(clk_sys), .btn_req(btn_req), .whl_req(whl_req), .pos_req(pos_req),
		.step_cw(step_cw), .step_ccw(step_ccw), .btn_touch(btn_touch),
		.wheel_touch(wheel_touch), .rot_cw(rot_cw), .rot_ccw(rot_ccw),
		.wheel_pos(wheel_pos), .wheel_position_max(wheel_position_max));

	// ==========================================================
	// Clock and wake counting
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Wake pulses last one cycle, so count them rather than poll.
	always @(posedge clk_sys) begin
		if (wake_pulse === 1'b1) begin
			wakes <= wakes + 1;
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask : wr

	// Read data is valid the cycle after the strobe is taken.
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re   <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 chk(reg_rdata, exp, "register read");
	endtask : rchk

	// Outputs are levels; a few scans let segment tracking settle too.
	task automatic sense(input logic [11:0] b, input logic w, input logic [9:0] p);
		@(posedge clk_sys);
		btn_req <= b;
		whl_req <= w;
		pos_req <= p;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : sense

	task automatic step(input logic cw);
		@(posedge clk_sys);
		step_cw  <= cw;
		step_ccw <= ~cw;
		@(posedge clk_sys);
		step_cw  <= 1'b0;
		step_ccw <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic key(input int n);
		sense(12'h001 << n, 1'b0, 10'd0);
		sense(12'h000, 1'b0, 10'd0);
	endtask : key

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// A hang costs a mismatch and still ends through the normal verdict.
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		close_out();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		rchk(OFS_HYST, 8'h02);
		rchk(OFS_GRP1_HIGH, 8'h00);
		rchk(OFS_AUTOLIGHT, 8'hFF);
		rchk(8'h20, 8'h00);
		wr(OFS_HYST, 8'h65);
		rchk(OFS_HYST, 8'h64);
		wr(OFS_HYST, 8'h00);
		rchk(OFS_HYST, 8'h00);
		wr(OFS_GRP1_HIGH, 8'hFF);
		rchk(OFS_GRP1_HIGH, 8'h7F);
		wr(OFS_GRP1_LOW, 8'hA5);
		rchk(OFS_GRP1_LOW, 8'hA5);
		$display("test registers done");
		// Every button code on pin 0.
		for (int n = 0; n < 12; n++) begin
			wr(OFS_LIGHT_MAP3, 8'(n));
			sense(12'h001 << n, 1'b0, 10'd0);
			chk(output_pin[0], 1'b1, "pin0 on touch");
			sense(12'h000, 1'b0, 10'd0);
			chk(output_pin[0], 1'b0, "pin0 off release");
		end
		wr(OFS_LIGHT_MAP3, 8'h04);
		sense(12'h010, 1'b0, 10'd0);
		chk(output_pin, 8'h01, "pin0 follows button 4");
		sense(12'h001, 1'b0, 10'd0);
		chk(output_pin, 8'hFE, "default code pins");
		$display("test button mapping done");
		wr(OFS_GRP1_HIGH, 8'h40);
		wr(OFS_GRP1_LOW, 8'h08);
		wr(OFS_GRP0_LOW, 8'h03);
		wr(OFS_LIGHT_MAP3, 8'h0C);
		wr(OFS_LIGHT_MAP1, 8'h0D);
		sense(12'h002, 1'b0, 10'd0);
		chk(output_pin[0], 1'b1, "group0 button 1");
		sense(12'h004, 1'b0, 10'd0);
		chk(output_pin[0], 1'b0, "group0 button 2");
		sense(12'h000, 1'b1, 10'd0);
		chk(output_pin[4], 1'b1, "group1 wheel touch");
		sense(12'h008, 1'b0, 10'd0);
		chk(output_pin[4], 1'b1, "group1 button 3");
		sense(12'h010, 1'b0, 10'd0);
		chk(output_pin[4], 1'b0, "group1 button 4");
		$display("test groups done");
		wr(OFS_LIGHT_MAP2, 8'hEF);
		sense(12'h000, 1'b1, 10'd0);
		step(1'b1);
		chk(output_pin[3:2], 2'b01, "clockwise");
		step(1'b0);
		chk(output_pin[3:2], 2'b10, "counter-clockwise");
		sense(12'h000, 1'b0, 10'd0);
		chk(output_pin[3:2], 2'b00, "rotation release");
		$display("test rotation done");
		wr(OFS_GRP0_HIGH, 8'h40);
		wr(OFS_GRP0_LOW, 8'h00);
		wr(OFS_LIGHT_MAP3, 8'hCC);
		wr(OFS_LIGHT_MAP2, 8'h0C);
		sense(12'h000, 1'b1, 10'd100);
		chk(output_pin[2:0], 3'b001, "lowest segment");
		sense(12'h000, 1'b1, 10'd500);
		chk(output_pin[2:0], 3'b010, "middle segment");
		sense(12'h000, 1'b1, 10'd900);
		chk(output_pin[2:0], 3'b100, "top segment");
		wr(OFS_HYST, 8'h0A);
		sense(12'h000, 1'b1, 10'd620);
		chk(output_pin[2:0], 3'b100, "hysteresis holds segment");
		sense(12'h000, 1'b1, 10'd500);
		chk(output_pin[2:0], 3'b010, "hysteresis crossed");
		sense(12'h000, 1'b0, 10'd900);
		chk(output_pin[2:0], 3'b000, "segment release");
		$display("test segments done");
		wr(OFS_AUTOLIGHT, 8'hFC);
		@(posedge clk_sys);
		host_pin_value <= 8'h03;
		sense(12'h000, 1'b0, 10'd0);
		chk(output_pin[1:0], 2'b11, "host driven pins");
		wr(OFS_AUTOLIGHT, 8'hFF);
		$display("test host control done");
		wr(OFS_WAKE_LEN, 8'h02);
		wr(OFS_WAKE_KEYS2, 8'h52);
		@(posedge clk_sys);
		doze_active <= 1'b1;
		base = wakes;
		key(2);
		key(6);
		key(5);
		chk(16'(wakes - base), 16'd0, "broken sequence");
		key(2);
		key(5);
		chk(16'(wakes - base), 16'd1, "two key sequence");
		wr(OFS_WAKE_LEN, 8'h01);
		wr(OFS_WAKE_KEYS2, 8'h0C);
		base = wakes;
		sense(12'h000, 1'b1, 10'd0);
		chk(16'(wakes - base), 16'd1, "wheel touch key");
		sense(12'h000, 1'b0, 10'd0);
		wr(OFS_WAKE_KEYS2, 8'h0E);
		base = wakes;
		sense(12'h000, 1'b1, 10'd0);
		step(1'b1);
		chk(16'(wakes - base), 16'd1, "clockwise key");
		sense(12'h000, 1'b0, 10'd0);
		wr(OFS_WAKE_LEN, 8'h00);
		base = wakes;
		sense(12'h080, 1'b0, 10'd0);
		chk(16'(wakes - base), 16'd1, "any event wake");
		sense(12'h000, 1'b0, 10'd0);
		wr(OFS_WAKE_LEN, 8'h06);
		base = wakes;
		key(2);
		chk(16'(wakes - base), 16'd0, "sensor wake off");
		@(posedge clk_sys);
		input_pin_wake <= 1'b1;
		@(posedge clk_sys);
		input_pin_wake <= 1'b0;
		host_wake_cmd  <= 1'b1;
		@(posedge clk_sys);
		host_wake_cmd <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(16'(wakes - base), 16'd2, "pin and host wake");
		$display("test wake done");
		close_out();
	end
endmodule : test_touch_event_light_wake_mapper
